// ==== verilog/drwk_defs.svh ====
// Purpose: constants for the range and watchdog service block
// Assumes: 25 MHz system clock
// Notes: timing counts derived from times in their own units
`ifndef DRWK_DEFS_SVH
`define DRWK_DEFS_SVH
`define DRWK_SW_PREFIX      3'h4
`define DRWK_RESET_CODE     12'h555
`define DRWK_SERVICE_CODE   12'h195
`define DRWK_USER_BIT       12
`define DRWK_CTRL_PREFIX    1'h0
`define DRWK_OVR_BIT        3
`define DRWK_CLK_MHZ        25
`define DRWK_TIMEOUT_MS     100
`define DRWK_TIMEOUT_CYC    (`DRWK_TIMEOUT_MS * 1000 * `DRWK_CLK_MHZ)
`define DRWK_RANGE_RESET    3'h0
`endif

// ==== verilog/drwk_pkg.sv ====
// Purpose: types for the range and watchdog service block
// Assumes: nothing beyond the header
// Notes: range codes follow the three-bit select field
package drwk_pkg;
	typedef enum logic [2:0] {
		DRWK_R_0_5V    = 3'h0,
		DRWK_R_0_10V   = 3'h1,
		DRWK_R_PM5V    = 3'h2,
		DRWK_R_PM10V   = 3'h3,
		DRWK_R_4_20MA  = 3'h4,
		DRWK_R_0_20MA  = 3'h5,
		DRWK_R_0_24MA  = 3'h6,
		DRWK_R_RSVD    = 3'h7
	} drwk_range_t;
	typedef struct packed {
		logic        voltage;
		logic        current;
		logic        bipolar;
		logic        overrange;
	} drwk_mode_t;
	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} drwk_word_t;
endpackage

// ==== verilog/drwk_serial_rx.sv ====
// Purpose: captures 16-bit serial words from the host link
// Assumes: link pins are asynchronous; sampled by sys_clk
// Notes: link clock must be well below sys_clk / 4
`timescale 1ns/1ps
`include "drwk_defs.svh"
module drwk_serial_rx (
	input  wire logic                sys_clk,
	input  wire logic                sys_rst,
	input  wire logic                link_sclk,
	input  wire logic                link_sync_n,
	input  wire logic                link_sdi,
	output      drwk_pkg::drwk_word_t word
);
	import drwk_pkg::*;
	typedef struct packed {
		logic [1:0]  sclk_s;
		logic [1:0]  sync_s;
		logic [1:0]  sdi_s;
		logic        sclk_d;
		logic [15:0] shift;
		logic [4:0]  count;
		drwk_word_t  out;
	} drwk_rx_state_t;
	drwk_rx_state_t st;
	drwk_rx_state_t next_st;
	logic           fall;
	// Two-stage synchronisers, then edge detect on second stage only
	always_comb begin
		next_st = st;
		next_st.sclk_s = {st.sclk_s[0], link_sclk};
		next_st.sync_s = {st.sync_s[0], link_sync_n};
		next_st.sdi_s = {st.sdi_s[0], link_sdi};
		next_st.sclk_d = st.sclk_s[1];
		next_st.out.valid = 1'b0;
		fall = st.sclk_d & ~st.sclk_s[1];
		if (st.sync_s[1]) begin
			// Frame ends on sync rise; a short frame is dropped
			if (st.count == 5'h10) begin
				next_st.out.valid = 1'b1;
				next_st.out.data = st.shift;
			end
			next_st.count = 5'h00;
		end else if (fall && st.count != 5'h10) begin
			next_st.shift = {st.shift[14:0], st.sdi_s[1]};
			next_st.count = st.count + 5'h01;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st <= '{sclk_s: 2'h0, sync_s: 2'h3, sdi_s: 2'h0, sclk_d: 1'b0,
				shift: 16'h0000, count: 5'h00, out: '0};
		end else begin
			st <= next_st;
		end
	end
	assign word = st.out;
endmodule

// ==== verilog/drwk_range_wdog.sv ====
// Purpose: range/overrange config and software register with watchdog
// Assumes: host writes 16-bit words; control word prefix bit D15 = 0
// Notes: watchdog enable is a plain input from the main control logic
`timescale 1ns/1ps
`include "drwk_defs.svh"
module drwk_range_wdog #(
	parameter int unsigned TIMEOUT_CYC = `DRWK_TIMEOUT_CYC,
	parameter int unsigned CHANNELS    = 4
) (
	input  wire logic                     sys_clk,
	input  wire logic                     sys_rst,
	input  wire logic                     link_sclk,
	input  wire logic                     link_sync_n,
	input  wire logic                     link_sdi,
	input  wire logic                     wdog_enable,
	output      drwk_pkg::drwk_range_t    range_select [CHANNELS],
	output      drwk_pkg::drwk_mode_t     range_mode [CHANNELS],
	output      logic                     user_toggle,
	output      logic                     soft_reset,
	output      logic                     wdog_fault,
	output      logic                     fault_alert_n
);
	import drwk_pkg::*;
	typedef struct packed {
		logic [CHANNELS-1:0][2:0] rng;
		logic [CHANNELS-1:0]      ovr;
		logic                     toggle;
		logic                     srst;
		logic [31:0]              wd_count;
		logic                     fault;
		logic [1:0]               en_s;
	} drwk_state_t;
	drwk_state_t st;
	drwk_state_t next_st;
	drwk_word_t  word;
	logic        is_sw;
	logic        is_ctrl;
	logic [11:0] code;
	logic [1:0]  chan;
	logic        wd_en;

	// Range code to output kind
	function automatic drwk_mode_t decode_mode(input logic [2:0] r, input logic o);
		drwk_mode_t m;
		m = '0;
		case (drwk_range_t'(r))
			DRWK_R_0_5V, DRWK_R_0_10V: m.voltage = 1'b1;
			DRWK_R_PM5V: begin
				m.voltage = 1'b1;
				m.bipolar = 1'b1;
			end
			DRWK_R_PM10V: begin
				m.voltage = 1'b1;
				m.bipolar = 1'b1;
			end
			DRWK_R_4_20MA, DRWK_R_0_20MA, DRWK_R_0_24MA: m.current = 1'b1;
			default: m = '0;
		endcase
		// Overrange only applies to voltage ranges
		m.overrange = o & m.voltage;
		return m;
	endfunction

	drwk_serial_rx u_rx (
		.sys_clk     (sys_clk),
		.sys_rst     (sys_rst),
		.link_sclk   (link_sclk),
		.link_sync_n (link_sync_n),
		.link_sdi    (link_sdi),
		.word        (word)
	);

	// Word classification
	assign is_sw = word.valid && word.data[15:13] == `DRWK_SW_PREFIX;
	assign is_ctrl = word.valid && word.data[15] == `DRWK_CTRL_PREFIX;
	assign code = word.data[11:0];
	assign chan = word.data[14:13];
	assign wd_en = st.en_s[1];

	// Next-state logic
	always_comb begin
		next_st = st;
		next_st.srst = 1'b0;
		next_st.en_s = {st.en_s[0], wdog_enable};
		if (is_ctrl && 32'(chan) < CHANNELS) begin
			next_st.rng[chan] = word.data[2:0];
			next_st.ovr[chan] = word.data[`DRWK_OVR_BIT];
		end
		// Watchdog count; stops and clears while disabled
		if (!wd_en) begin
			next_st.wd_count = 32'h0;
			next_st.fault = 1'b0;
		end else if (st.wd_count >= TIMEOUT_CYC - 1) begin
			next_st.fault = 1'b1;
		end else begin
			next_st.wd_count = st.wd_count + 32'h1;
		end
		if (is_sw) begin
			next_st.toggle = word.data[`DRWK_USER_BIT];
			if (code == `DRWK_SERVICE_CODE) begin
				// Service restarts count and clears fault in the same step
				next_st.wd_count = 32'h0;
				next_st.fault = 1'b0;
			end
			if (code == `DRWK_RESET_CODE) begin
				next_st.srst = 1'b1;
			end
		end
		// Soft reset returns config to defaults
		if (st.srst) begin
			next_st.rng = '0;
			next_st.ovr = '0;
			next_st.toggle = 1'b0;
			next_st.wd_count = 32'h0;
			next_st.fault = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Outputs per channel
	always_comb begin
		for (int i = 0; i < CHANNELS; i++) begin
			range_select[i] = drwk_range_t'(st.rng[i]);
			range_mode[i] = decode_mode(st.rng[i], st.ovr[i]);
		end
	end
	assign user_toggle = st.toggle;
	assign soft_reset = st.srst;
	assign wdog_fault = st.fault;
	assign fault_alert_n = ~st.fault;
endmodule

// ==== tb/drwk_range_wdog_checker.sv ====
// Purpose: port assertions for the range and watchdog block
// Assumes: channel 0 stands in for every channel
// Notes: sees design outputs plus link_sync_n and wdog_enable; quiet link means no word lands
`timescale 1ns/1ps
module drwk_range_wdog_checker #(
	parameter int unsigned CHANNELS = 4
) (
	input wire logic             sys_clk,
	input wire logic             sys_rst,
	input wire logic             link_sync_n,
	input wire logic             wdog_enable,
	input drwk_pkg::drwk_range_t range_select [CHANNELS],
	input drwk_pkg::drwk_mode_t  range_mode [CHANNELS],
	input wire logic             user_toggle,
	input wire logic             soft_reset,
	input wire logic             wdog_fault,
	input wire logic             fault_alert_n
);
	import drwk_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// Eight idle samples outlast the capture latency
	sequence quiet_link;
		link_sync_n [*8];
	endsequence
	a_alert_inverse: assert property (fault_alert_n == !wdog_fault)
		else $error("alert not inverse of fault");
	a_reset_defaults: assert property ($fell(sys_rst) |-> range_select[0] == DRWK_R_0_5V && !range_mode[0].overrange)
		else $error("bad values after reset");
	a_soft_pulse: assert property (soft_reset |=> !soft_reset)
		else $error("soft reset longer than one cycle");
	a_soft_clears: assert property (soft_reset |=> ##[0:1] (range_select[0] == DRWK_R_0_5V && !wdog_fault))
		else $error("soft reset left state behind");
	a_quiet_stable: assert property (quiet_link |-> $stable(range_select[0]) && $stable(user_toggle))
		else $error("state changed with link idle");
	a_current_no_ovr: assert property (range_mode[0].current |-> !range_mode[0].overrange)
		else $error("overrange on current range");
	a_bipolar_codes: assert property (range_mode[0].bipolar == (range_select[0] inside {DRWK_R_PM5V, DRWK_R_PM10V}))
		else $error("bipolar decode wrong");
	a_disabled_quiet: assert property (!wdog_enable [*4] |-> !wdog_fault)
		else $error("fault while watchdog disabled");
endmodule

// ==== tb/drwk_host_model.sv ====
// Purpose: serial host sending 16-bit words
// Assumes: link clock idles high and stands still between frames
// Notes: data changes on the rising link edge
`timescale 1ns/1ps
module drwk_host_model (
	output logic link_sclk,
	output logic link_sync_n,
	output logic link_sdi
);
	// Idle levels from time zero
	initial begin
		link_sclk = 1'b1;
		link_sync_n = 1'b1;
		link_sdi = 1'b0;
	end
	// MSB first, exactly sixteen falling edges, then a long idle gap
	task automatic send(input logic [15:0] w);
		#13 link_sync_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			link_sdi = w[i];
			#160 link_sclk = 1'b0;
			#160 link_sclk = 1'b1;
		end
		#160 link_sync_n = 1'b1;
		link_sdi = ~w[0]; // No stale bit once released
		#200;
	endtask
endmodule

// ==== tb/drwk_range_wdog_tb.sv ====
// Purpose: self-checking bench for the range and watchdog block
// Assumes: host model paces every word
// Notes: timeout shortened to 200 cycles
`timescale 1ns/1ps
module drwk_range_wdog_tb;
	import drwk_pkg::*;
	localparam int unsigned TO = 200;
	logic        sys_clk = 1'b0;
	logic        sys_rst;
	logic        wdog_enable;
	logic        link_sclk, link_sync_n, link_sdi;
	drwk_range_t range_select [4];
	drwk_mode_t  range_mode [4];
	logic        user_toggle, soft_reset, wdog_fault, fault_alert_n;
	int          fail_count = 0, checks_done = 0, cyc = 0, pulses = 0;
	// Word, expected mode, expected range code
	logic [23:0] rows [7] = '{24'h000991, 24'h2002a2, 24'h400bb3, 24'h600c44, 24'h000d45, 24'h200646, 24'h400890};
	drwk_range_wdog #(.TIMEOUT_CYC(TO), .CHANNELS(4)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.link_sclk(link_sclk), .link_sync_n(link_sync_n), .link_sdi(link_sdi), .wdog_enable(wdog_enable),
		.range_select(range_select), .range_mode(range_mode), .user_toggle(user_toggle),
		.soft_reset(soft_reset), .wdog_fault(wdog_fault), .fault_alert_n(fault_alert_n));
	drwk_host_model host (.link_sclk(link_sclk), .link_sync_n(link_sync_n), .link_sdi(link_sdi));
	always #20 sys_clk = ~sys_clk;
	// Hang guard; pulse counter catches one-cycle strobes
	always @(posedge sys_clk) begin
		cyc++;
		if (soft_reset === 1'b1) pulses++;
		if (cyc == 20000) begin
			fail_count++;
			results();
		end
	end
	function automatic logic [15:0] rg(input int c);
		return {9'h0, range_select[c], range_mode[c]};
	endfunction
	function automatic logic [15:0] st();
		return {13'h0, user_toggle, wdog_fault, fault_alert_n};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Send one word and let the outputs settle
	task automatic put(input logic [15:0] w);
		host.send(w);
		repeat (3) @(posedge sys_clk);
		#1;
	endtask
	task automatic wait_out();
		repeat (TO + 20) @(posedge sys_clk);
		#1;
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Main sequence: reset, table of control words, then hand cases
	initial begin
		sys_rst = 1'b1;
		wdog_enable = 1'b0;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		#1;
		for (int c = 0; c < 4; c++) chk(rg(c), 16'h0008);
		chk(st(), 16'h0001);
		foreach (rows[i]) begin
			put(rows[i][23:8]);
			chk(rg(rows[i][22:21]), {9'h0, rows[i][2:0], rows[i][7:4]});
		end
		put(16'h9000);
		chk(st(), 16'h0005);
		put(16'h8000);
		chk(st(), 16'h0001);
		@(posedge sys_clk) wdog_enable <= 1'b1;
		repeat (3) put(16'h8195);
		chk(st(), 16'h0001);
		wait_out();
		chk(st(), 16'h0002);
		put(16'h8195);
		chk(st(), 16'h0001);
		@(posedge sys_clk) wdog_enable <= 1'b0;
		wait_out();
		chk(st(), 16'h0001);
		put(16'h9554);
		chk(rg(0), 16'h0054);
		chk(pulses[15:0], 16'h0000);
		put(16'h8555);
		chk(pulses[15:0], 16'h0001);
		for (int c = 0; c < 4; c++) chk(rg(c), 16'h0008);
		// Mid-run reset must drop a written range and overrange
		put(16'h000b);
		chk(rg(0), 16'h003b);
		@(posedge sys_clk) sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk(rg(0), 16'h0008);
		results();
	end
endmodule
bind drwk_range_wdog drwk_range_wdog_checker #(.CHANNELS(CHANNELS)) u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
	.link_sync_n(link_sync_n), .wdog_enable(wdog_enable), .range_select(range_select), .range_mode(range_mode),
	.user_toggle(user_toggle), .soft_reset(soft_reset), .wdog_fault(wdog_fault), .fault_alert_n(fault_alert_n));
